// ### rtl/psr_params.svh
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

`define PSR_WIDTH     16
`define PSR_MSB       15
`define PSR_BUF_DEPTH 2
`define PSR_SYNC_RST  2'b00
`define PSR_FILL_CNT  5'h10

`endif

// ### rtl/psr_pkg.sv
`include "psr_params.svh"

package psr_pkg;

	typedef enum logic [0:0] {
		PSR_SHIFT,
		PSR_LOAD
	} psr_op_e;

	typedef struct packed {
		psr_op_e                  op;
		logic [`PSR_MSB:0]        data;
		logic                     si;
	} psr_cmd_s;

endpackage

// ### rtl/psr_stream_if.sv
`timescale 1ns/1ns

interface psr_stream_if;
	logic              valid;
	logic              ready;
	psr_pkg::psr_cmd_s cmd;

	modport src (output valid, output cmd, input ready);
	modport snk (input valid, input cmd, output ready);
endinterface

// ### rtl/psr_cmd_buf.sv
`timescale 1ns/1ns
`include "psr_params.svh"

module psr_cmd_buf (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Streams
	psr_stream_if.snk up,
	psr_stream_if.src dn
);

	psr_pkg::psr_cmd_s mem_q [`PSR_BUF_DEPTH];
	logic              wr_ptr_q;
	logic              rd_ptr_q;
	logic [1:0]        count_q;
	logic [1:0]        count_d;
	logic              push;
	logic              pop;

	assign up.ready = (count_q != 2'h2);
	assign dn.valid = (count_q != 2'h0);
	assign dn.cmd   = mem_q[rd_ptr_q];
	assign push     = up.valid && up.ready;
	assign pop      = dn.valid && dn.ready;
	assign count_d  = count_q + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= up.cmd;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			count_q  <= count_d;
		end
	end

endmodule // psr_cmd_buf

// ### rtl/psr_shift_reg.sv
`timescale 1ns/1ns
`include "psr_params.svh"

module psr_shift_reg (
	// Clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_b_in,
	// Host pins
	input  wire logic              shift_clock_n_in,
	input  wire logic              chip_sel_n_in,
	input  wire logic              load_sel_in,
	input  wire logic [`PSR_MSB:0] par_data_in,
	input  wire logic              ser_data_in,
	output logic                   ser_data_out,
	output logic                   cmd_ready_out,
	// Word snapshot stream
	output logic [`PSR_MSB:0]      word_out,
	output logic                   word_valid_out,
	input  wire logic              word_ready_in
);

	logic [1:0]         rst_sync_q;
	logic               rst_b;
	logic               sclk_prev_q;
	logic               fall;
	logic [`PSR_MSB:0]  stage_q;
	logic [`PSR_MSB:0]  stage_d;
	logic               ser_q;
	logic [`PSR_MSB:0]  word_q;
	logic               word_valid_q;
	logic               ready_q;
	logic               fire;
	logic               is_load;
	logic               filled_q;
	logic [4:0]         shift_cnt_q;

	psr_stream_if in_s ();
	psr_stream_if out_s ();

	// Reset release
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_sync_q <= `PSR_SYNC_RST;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_q[1];

	// Falling edge of the shift clock, gated by the select
	assign fall         = sclk_prev_q && !shift_clock_n_in;
	assign in_s.valid   = fall && !chip_sel_n_in;
	assign in_s.cmd.op  = load_sel_in ? psr_pkg::PSR_LOAD
	                                  : psr_pkg::PSR_SHIFT;
	assign in_s.cmd.data = par_data_in;
	assign in_s.cmd.si   = ser_data_in;

	psr_cmd_buf u_buf (
		.clk   (clock_in),
		.rst_b (rst_b),
		.up    (in_s),
		.dn    (out_s)
	);

	// Register stage drains when the snapshot slot is free or is being read out this cycle
	assign out_s.ready = !word_valid_q || word_ready_in;
	assign fire        = out_s.valid && out_s.ready;
	assign is_load     = (out_s.cmd.op == psr_pkg::PSR_LOAD);
	assign stage_d     = is_load ? out_s.cmd.data
	                   : {stage_q[`PSR_MSB-1:0], out_s.cmd.si};

	// Stages carry no reset
	always_ff @(posedge clock_in) begin
		if (fire) begin
			stage_q <= stage_d;
			ser_q   <= stage_d[`PSR_MSB];
			word_q  <= stage_d;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b) begin
		if (!rst_b) begin
			sclk_prev_q  <= 1'b0;
			word_valid_q <= 1'b0;
			ready_q      <= 1'b0;
			filled_q     <= 1'b0;
			shift_cnt_q  <= 5'h00;
		end else begin
			sclk_prev_q  <= shift_clock_n_in;
			word_valid_q <= fire || (word_valid_q && !word_ready_in);
			ready_q      <= in_s.ready;
			if (fire && !filled_q) begin
				filled_q    <= is_load || (shift_cnt_q == `PSR_FILL_CNT - 5'h01);
				shift_cnt_q <= shift_cnt_q + 5'h01;
			end
		end
	end

	assign ser_data_out   = ser_q;
	assign cmd_ready_out  = ready_q;
	assign word_out       = word_q;
	assign word_valid_out = word_valid_q;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b);

	sequence s_shift_fire;
		fire && !is_load;
	endsequence

	sequence s_desel_fall;
		fall && chip_sel_n_in && !out_s.valid;
	endsequence

	property p_load;
		fire && is_load |=> stage_q == $past(out_s.cmd.data);
	endproperty
	a_load: assert property (p_load)
		else $error("parallel load not taken");

	property p_shift;
		s_shift_fire |=> stage_q[`PSR_MSB:1] == $past(stage_q[`PSR_MSB-1:0]);
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift did not move stages up");

	property p_advance;
		s_shift_fire |=> stage_q[0] == $past(out_s.cmd.si);
	endproperty
	a_advance: assert property (p_advance)
		else $error("serial bit did not advance");

	property p_serout;
		filled_q |-> ser_data_out == stage_q[`PSR_MSB];
	endproperty
	a_serout: assert property (p_serout)
		else $error("serial output not top stage");

	property p_hold;
		filled_q && !fire |=> $stable(stage_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stages changed without a command");

	property p_gate;
		fall && chip_sel_n_in |-> !in_s.valid;
	endproperty
	a_gate: assert property (p_gate)
		else $error("edge accepted while deselected");

	property p_word;
		fire |=> word_valid_out && word_out == stage_q;
	endproperty
	a_word: assert property (p_word)
		else $error("snapshot word mismatch");

	property p_filled;
		fire && is_load |=> filled_q;
	endproperty
	a_filled: assert property (p_filled)
		else $error("load did not mark register filled");

	property p_load_out;
		fire && is_load |=>
			ser_data_out == $past(out_s.cmd.data[`PSR_MSB]);
	endproperty
	a_load_out: assert property (p_load_out)
		else $error("serial output not top bit after load");

	property p_shift_out;
		s_shift_fire |=> ser_data_out == $past(stage_q[`PSR_MSB-1]);
	endproperty
	a_shift_out: assert property (p_shift_out)
		else $error("serial bit did not reach the output");

	property p_ignore;
		s_desel_fall |=> !out_s.valid ##1 $stable(stage_q);
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("deselected edge changed the stages");

	property p_take;
		fall && !chip_sel_n_in && in_s.ready |=> out_s.valid;
	endproperty
	a_take: assert property (p_take)
		else $error("selected edge not queued");

	property p_word_stand;
		word_valid_out && !word_ready_in |=>
			word_valid_out && $stable(word_out);
	endproperty
	a_word_stand: assert property (p_word_stand)
		else $error("snapshot word dropped while stalled");

	property p_word_drop;
		word_valid_out && word_ready_in && !fire |=> !word_valid_out;
	endproperty
	a_word_drop: assert property (p_word_drop)
		else $error("snapshot word not released");

	property p_ready_out;
		rst_b |=> cmd_ready_out == $past(in_s.ready);
	endproperty
	a_ready_out: assert property (p_ready_out)
		else $error("ready output does not follow buffer");

	property p_rst_quiet;
		disable iff (1'b0)
		!rst_b |=> !word_valid_out && !cmd_ready_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs active during reset");

	property p_fill_shift;
		fire && !is_load && !filled_q &&
			shift_cnt_q == `PSR_FILL_CNT - 5'h01 |=> filled_q;
	endproperty
	a_fill_shift: assert property (p_fill_shift)
		else $error("sixteen shifts did not mark register filled");

	property p_fill_cause;
		$rose(filled_q) |-> $past(is_load) || shift_cnt_q == `PSR_FILL_CNT;
	endproperty
	a_fill_cause: assert property (p_fill_cause)
		else $error("register marked filled too early");

	property p_count_stop;
		filled_q |=> $stable(shift_cnt_q);
	endproperty
	a_count_stop: assert property (p_count_stop)
		else $error("fill counter moved after fill");

	property p_load_word;
		fire && is_load |=> word_out == $past(out_s.cmd.data);
	endproperty
	a_load_word: assert property (p_load_word)
		else $error("snapshot word not the loaded word");

endmodule // psr_shift_reg

// ### sim/psr_host_model.sv
`timescale 1ns/1ns

module psr_host_model (
	// Clock and request
	input  wire logic clock_in,
	input  wire logic go_in,
	// Host pin
	output logic      shift_clock_n_out
);
	// Idles low, so the shift clock always rises with the clock low
	always_ff @(negedge clock_in) begin
		shift_clock_n_out <= go_in;
	end
endmodule // psr_host_model

// ### sim/piso_shift_register_16_test.sv
`timescale 1ns/1ns

module piso_shift_register_16_test;
	logic        clock_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        go       = 1'b0;
	logic        sclk_n;
	logic        sel_n    = 1'b1;
	logic        ld       = 1'b0;
	logic [15:0] par      = 16'h0000;
	logic        si       = 1'b0;
	logic        so;
	logic        rdy;
	logic [15:0] word;
	logic        wvalid;
	logic        wready   = 1'b0;
	logic [15:0] m;
	logic [15:0] exp_q[$];
	int          n_mismatch   = 0;
	int          total_checks = 0;
	always #5 clock_in = ~clock_in;
	psr_host_model host_u (.clock_in(clock_in), .go_in(go),
		.shift_clock_n_out(sclk_n));
	psr_shift_reg dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.shift_clock_n_in(sclk_n), .chip_sel_n_in(sel_n),
		.load_sel_in(ld), .par_data_in(par), .ser_data_in(si),
		.ser_data_out(so), .cmd_ready_out(rdy), .word_out(word),
		.word_valid_out(wvalid), .word_ready_in(wready));
	task automatic cmp16(string nm, logic [15:0] e, logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp1(string nm, logic e, logic s);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", nm, e, s);
		end
	endtask
	function automatic logic [15:0] nxt(logic l, logic [15:0] p, logic s);
		return l ? p : {m[14:0], s};
	endfunction
	task automatic op(logic c, logic l, logic [15:0] p, logic s);
		int k;
		@(negedge clock_in);
		sel_n <= c;
		ld    <= l;
		par   <= p;
		si    <= s;
		go    <= 1'b1;
		@(negedge clock_in);
		go <= 1'b0;
		if (!c) begin
			m = nxt(l, p, s);
			exp_q.push_back(m);
		end
		k = 0;
		repeat (4) @(negedge clock_in);
		while (exp_q.size() != 0 && k < 100) begin
			@(negedge clock_in);
			k++;
		end
		cmp16("queue", 16'h0000, 16'(exp_q.size()));
		cmp1("serial", m[15], so);
		cmp1("ready", 1'b1, rdy);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(negedge clock_in) begin
		wready <= 1'($urandom_range(0, 1));
	end
	always @(posedge clock_in) begin
		if (wvalid && wready) begin
			if (exp_q.size() == 0)
				cmp16("spurious", 16'h0000, 16'hFFFF);
			else
				cmp16("word", exp_q.pop_front(), word);
		end
	end
	initial begin
		#200000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		void'($urandom(28098));
		repeat (10) @(negedge clock_in);
		rst_b_in <= 1'b1;
		repeat (5) @(negedge clock_in);
		op(1'b0, 1'b1, 16'h8001, 1'b0);
		for (int i = 0; i < 16; i++) begin
			op(1'b0, 1'b0, 16'hFFFF, 1'(i));
		end
		op(1'b1, 1'b1, 16'h0000, 1'b1);
		op(1'b1, 1'b0, 16'h0000, 1'b1);
		$display("corner test done");
		rst_b_in <= 1'b0;
		repeat (3) @(negedge clock_in);
		cmp1("valid_rst", 1'b0, wvalid);
		cmp1("ready_rst", 1'b0, rdy);
		cmp1("keep_rst", m[15], so);
		rst_b_in <= 1'b1;
		repeat (5) @(negedge clock_in);
		for (int i = 0; i < 16; i++) begin
			op(1'b0, 1'b0, 16'h0000, 1'($urandom_range(0, 1)));
		end
		$display("reset test done");
		for (int i = 0; i < 60; i++) begin
			op(1'($urandom_range(0, 3) == 0), 1'($urandom_range(0, 1)),
				16'($urandom), 1'($urandom_range(0, 1)));
		end
		$display("random test done");
		end_of_test();
	end
endmodule // piso_shift_register_16_test
